// ===== hdl/cnr_defines.vh
// Constants for the chain node router with extended flow-control decoding.
`ifndef CNR_DEFINES_VH
`define CNR_DEFINES_VH
`define CNR_CMD_EXT_FC 6'h37
`define CNR_CMD_LO 0
`define CNR_CMD_HI 5
`define CNR_LEN_BIT 6
`define CNR_SET_LO 8
`define CNR_SET_HI 10
`define CNR_PRIV_LO 12
`define CNR_PRIV_HI 15
`define CNR_REL0_LO 16
`define CNR_RETRY_SHORT_LO 24
`define CNR_RETRY_LONG_LO 56
`define CNR_SET_ALT 3'h0
`define CNR_SET_STREAM 3'h2
`define CNR_SET_LAST 3'h7
`define CNR_FWD_WIN_HI 40'hFFFFFFFFFF
`define CNR_FWD_WIN_LO 40'hFD00000000
`define CNR_CREDIT_W 4
`define CNR_KIND_BCAST 3'h0
`define CNR_KIND_DOWN 3'h1
`define CNR_KIND_UP 3'h2
`define CNR_KIND_RESP 3'h3
`define CNR_KIND_FC 3'h4
`define CNR_BUS_CTRL 4'h0
`define CNR_BUS_STAT 4'h4
`define CNR_BUS_CREDIT 4'h8
`define CNR_BUS_PEER 4'hC
`endif

// ===== hdl/cnr_credit.v
// Saturating transmit credit counter for one buffer type.
`timescale 1ns/1ps
`include "cnr_defines.vh"
module cnr_credit #(
  parameter W = `CNR_CREDIT_W
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Release count and consume strobe.
  input wire [1:0] add_i,
  input wire add_en_i,
  input wire take_i,
  // Current credit.
  output reg [W-1:0] count_o
);
  wire [W:0] sum;
  wire [W:0] dec;
  // Extras beyond full are discarded so the counter never wraps.
  assign sum = {1'b0, count_o} + {{(W-1){1'b0}}, add_i};
  assign dec = (take_i && count_o != {W{1'b0}}) ? sum - {{W{1'b0}}, 1'b1}
                                                : sum;
  always @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= {W{1'b0}};
    end else if (add_en_i || take_i) begin
      count_o <= dec[W] ? {W{1'b1}} : dec[W-1:0];
    end
  end
endmodule

// ===== hdl/cnr_router.v
// Receive-side packet router of a chain node with flow-control decoding.
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cnr_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Extended flow-control packets never sent when all extended sets disabled.
// - Extended flow control covers only channel sets 0 to 7.
// - length_select 0 means four bytes, 1 means eight bytes.
// - Short form: byte0 length and command, byte1 set, byte2 release, byte3 ack.
// - Long form: bytes 2 to 5 release, byte 6 reserved, byte 7 ack.
// - set_private_bits carry neighbour information, zero when unused.
// - retry_ack_pointer only meaningful with retry enabled, else reserved.
// - Alternate set uses short form with four 2-bit counts.
// - Alternate posted and response counts release command and data together.
// - Stream set uses long form with sixteen 2-bit stream counts.
// - Each 2-bit count returns zero to three buffers of credit.
// - Broadcasts only posted; directed may be posted or nonposted.
// - Broadcasts are both accepted and forwarded.
// - Clumped unit tags are treated as equal for routing; upstream peer routing still reads each tag's own peer_route_reg bit.
// - Downstream accepted if tag zero, flag clear, address owned; else forwarded.
// - Downstream with compatibility flag accepted only at subtractive device.
// - Upstream accepted if peer routed, outside window and owned.
// - Bridge-origin responses to own tag accepted; all others forwarded.
// - Forwarded packets leave on the opposite link.
// - Tunnel accepts downstream packets from either link.
// - Uninitialised link: pend, or reject if discard flag set.
// - Forwarding toward a terminus link rejects instead.
// - Rejection drops all but nonposted requests, which get abort replies.
module cnr_router (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Incoming packet header, already decoded by the link layer.
  input wire pkt_valid_i,
  input wire pkt_link_i,
  input wire [63:0] pkt_data_i,
  input wire [2:0] pkt_kind_i,
  input wire pkt_nonposted_i,
  input wire pkt_compat_i,
  input wire pkt_bridge_i,
  input wire [4:0] pkt_tag_i,
  input wire [39:0] pkt_addr_i,
  input wire addr_owned_i,
  output reg pkt_ready_o,
  // Link state per link, from configuration logic.
  input wire [1:0] terminus_i,
  input wire [1:0] init_done_i,
  // Routing decision.
  output reg accept_o,
  output reg forward_o,
  output reg fwd_link_o,
  output reg reject_o,
  output reg abort_reply_o,
  output reg pend_o,
  // Decoded flow-control fields.
  output reg fc_valid_o,
  output reg [2:0] fc_set_o,
  output reg [3:0] fc_private_o,
  output reg [7:0] fc_retry_ptr_o,
  output reg fc_error_o,
  // Wishbone slave.
  input wire [3:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire we_i,
  input wire cyc_i,
  input wire stb_i,
  output reg [31:0] dat_o,
  output reg ack_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Control registers.
  reg [7:0] set_enable_reg;
  reg uninit_discard_reg;
  reg retry_en_reg;
  reg subtractive_reg;
  reg [4:0] node_tag_reg;
  reg [4:0] clump_top_reg;
  reg [31:0] peer_route_reg;
  reg [7:0] fc_err_count_reg;
  // Second stage of the link flag synchronisers; the only stage read.
  reg [1:0] term_s2_reg;
  reg [1:0] init_s2_reg;
  reg [31:0] rd_next;
  wire bus_hit;
  wire [15:0] alt_cnt;
  wire [3:0] alt_take;

  assign bus_hit = cyc_i && stb_i && !ack_o;

  // Bus writes take effect on the cycle the ack is raised.
  // The raised ack masks the hit, so a held request cannot write twice.
  always @(posedge clk_i) begin
    if (rst_i) begin
      set_enable_reg <= 8'h00;
      uninit_discard_reg <= 1'b0;
      retry_en_reg <= 1'b0;
      subtractive_reg <= 1'b0;
      node_tag_reg <= 5'h01;
      clump_top_reg <= 5'h00;
      peer_route_reg <= 32'h00000000;
    end else if (bus_hit && we_i) begin
      case (adr_i)
        `CNR_BUS_CTRL: begin
          if (sel_i[0]) set_enable_reg <= dat_i[7:0];
          if (sel_i[1]) begin
            uninit_discard_reg <= dat_i[8];
            retry_en_reg <= dat_i[9];
            subtractive_reg <= dat_i[10];
          end
          if (sel_i[2]) node_tag_reg <= dat_i[20:16];
          if (sel_i[3]) clump_top_reg <= dat_i[28:24];
        end
        `CNR_BUS_PEER: begin
          if (sel_i[0]) peer_route_reg[7:0] <= dat_i[7:0];
          if (sel_i[1]) peer_route_reg[15:8] <= dat_i[15:8];
          if (sel_i[2]) peer_route_reg[23:16] <= dat_i[23:16];
          if (sel_i[3]) peer_route_reg[31:24] <= dat_i[31:24];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped offsets read zero and are still acknowledged.
  // Status shows the synchronised link flags, the same ones routing uses.
  always @* begin
    rd_next = 32'h00000000;
    case (adr_i)
      `CNR_BUS_CTRL: rd_next = {3'h0, clump_top_reg, 3'h0, node_tag_reg,
                                5'h00, subtractive_reg, retry_en_reg,
                                uninit_discard_reg, set_enable_reg};
      `CNR_BUS_STAT: rd_next = {16'h0000, fc_err_count_reg,
                                4'h0, init_s2_reg, term_s2_reg};
      `CNR_BUS_CREDIT: rd_next = {16'h0000, alt_cnt};
      `CNR_BUS_PEER: rd_next = peer_route_reg;
      default: rd_next = 32'h00000000;
    endcase
  end

  // One wait-free ack per request; ack falls the cycle after.
  // Read data is registered with the ack: one cycle more, no glitches.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_hit;
      if (bus_hit && !we_i) dat_o <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flow-control decode.
  // The header word holds byte n at bits 8n+7 down to 8n.
  wire is_fc;
  wire len_long;
  wire [2:0] fc_set;
  wire fc_set_on;
  wire fc_bad;
  wire alt_ok;
  wire fc_take;

  assign is_fc = pkt_kind_i == `CNR_KIND_FC &&
                 pkt_data_i[`CNR_CMD_HI:`CNR_CMD_LO] == `CNR_CMD_EXT_FC;
  assign len_long = pkt_data_i[`CNR_LEN_BIT];
  assign fc_set = pkt_data_i[`CNR_SET_HI:`CNR_SET_LO];
  assign fc_set_on = set_enable_reg[fc_set];
  // Alternate set must be short, stream set must be long.
  // A wrong length is flagged as an error, never read as the other form.
  assign alt_ok = !(fc_set == `CNR_SET_ALT && len_long) &&
                  !(fc_set == `CNR_SET_STREAM && !len_long);
  assign fc_bad = !fc_set_on || !alt_ok;
  // Credit use is tracked outside this block, so the take side stays idle.
  assign alt_take = 4'h0;
  // Credits count only on the consume edge: the source holds valid one
  // cycle past it, so a gate on valid alone would add each release twice.
  assign fc_take = pkt_valid_i && !pkt_ready_o && is_fc && !fc_bad;

  // Alternate-set credits: posted, nonposted cmd, nonposted data, response.
  // One count serves both command and data for posted and response.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_alt
      cnr_credit #(.W(`CNR_CREDIT_W)) u_cred (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .add_i(pkt_data_i[`CNR_REL0_LO + 2*gi +: 2]),
        .add_en_i(fc_take && fc_set == `CNR_SET_ALT),
        .take_i(alt_take[gi]),
        .count_o(alt_cnt[4*gi +: 4])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Routing decision.
  wire tag_home;
  wire tag_mine;
  wire in_window;
  wire out_link;
  reg [1:0] term_s1_reg;
  reg [1:0] init_s1_reg;
  reg want_acc;
  reg want_fwd;

  // Link flags come from another domain; resynchronise them.
  // Only the second stage feeds logic; the first may still be settling.
  always @(posedge clk_i) begin
    if (rst_i) begin
      term_s1_reg <= 2'b00;
      term_s2_reg <= 2'b00;
      init_s1_reg <= 2'b00;
      init_s2_reg <= 2'b00;
    end else begin
      term_s1_reg <= terminus_i;
      term_s2_reg <= term_s1_reg;
      init_s1_reg <= init_done_i;
      init_s2_reg <= init_s1_reg;
    end
  end

  // Tags up to the clump top stand for the host. A node whose own tag
  // lies in that clump owns every tag of it when matching responses.
  assign tag_home = pkt_tag_i <= clump_top_reg;
  assign tag_mine = pkt_tag_i == node_tag_reg ||
                    (node_tag_reg <= clump_top_reg && tag_home);
  // The window runs to the top of the 40-bit space; one compare will do.
  assign in_window = pkt_addr_i >= `CNR_FWD_WIN_LO;
  assign out_link = ~pkt_link_i;

  // Acceptance and forwarding by packet kind.
  always @* begin
    want_acc = 1'b0;
    want_fwd = 1'b0;
    case (pkt_kind_i)
      `CNR_KIND_BCAST: begin
        want_acc = 1'b1;
        want_fwd = 1'b1;
      end
      `CNR_KIND_DOWN: begin
        // Either link may carry downstream traffic.
        if (pkt_compat_i) begin
          want_acc = subtractive_reg;
          want_fwd = !subtractive_reg;
        end else begin
          want_acc = tag_home && addr_owned_i;
          want_fwd = !want_acc;
        end
      end
      // Peer-routed tags reach a node only outside the reserved window.
      `CNR_KIND_UP: begin
        want_acc = peer_route_reg[pkt_tag_i] && !in_window &&
                   addr_owned_i;
        want_fwd = !want_acc;
      end
      `CNR_KIND_RESP: begin
        want_acc = pkt_bridge_i && tag_mine;
        want_fwd = !want_acc;
      end
      default: begin
        // Flow control and unknown kinds take no routing outcome.
        want_acc = 1'b0;
        want_fwd = 1'b0;
      end
    endcase
  end

  // Decisions look at the outgoing link only. A terminus flag wins over
  // the uninitialised state, so a dead link never holds a packet forever.
  wire link_dead;
  wire link_uninit;
  wire do_pend;
  wire do_rej;
  assign link_dead = term_s2_reg[out_link];
  assign link_uninit = !term_s2_reg[out_link] && !init_s2_reg[out_link];
  // A pended header keeps valid high, as the source sees no consume pulse.
  assign do_pend = want_fwd && link_uninit && !uninit_discard_reg;
  assign do_rej = want_fwd && (link_dead ||
                  (link_uninit && uninit_discard_reg));

  // Registered outcome; a pended packet is held until a flag sets.
  // Pulses clear every cycle, so one header never yields two outcomes.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pkt_ready_o <= 1'b0;
      accept_o <= 1'b0;
      forward_o <= 1'b0;
      fwd_link_o <= 1'b0;
      reject_o <= 1'b0;
      abort_reply_o <= 1'b0;
      pend_o <= 1'b0;
      fc_valid_o <= 1'b0;
      fc_set_o <= 3'h0;
      fc_private_o <= 4'h0;
      fc_retry_ptr_o <= 8'h00;
      fc_error_o <= 1'b0;
      fc_err_count_reg <= 8'h00;
    end else begin
      pkt_ready_o <= 1'b0;
      accept_o <= 1'b0;
      forward_o <= 1'b0;
      reject_o <= 1'b0;
      abort_reply_o <= 1'b0;
      fc_valid_o <= 1'b0;
      fc_error_o <= 1'b0;
      pend_o <= pkt_valid_i && !pkt_ready_o && do_pend;
      if (pkt_valid_i && !pkt_ready_o && !do_pend) begin
        pkt_ready_o <= 1'b1;
        if (pkt_kind_i == `CNR_KIND_FC) begin
          // Consumed here only.
          fc_valid_o <= is_fc && !fc_bad;
          fc_error_o <= !is_fc || fc_bad;
          if (!is_fc || fc_bad) begin
            fc_err_count_reg <= fc_err_count_reg + 8'h01;
          end
          fc_set_o <= fc_set;
          fc_private_o <= pkt_data_i[`CNR_PRIV_HI:`CNR_PRIV_LO];
          // With retry off the pointer is reserved and reads zero.
          if (!retry_en_reg) begin
            fc_retry_ptr_o <= 8'h00;
          end else if (len_long) begin
            fc_retry_ptr_o <= pkt_data_i[`CNR_RETRY_LONG_LO +: 8];
          end else begin
            fc_retry_ptr_o <= pkt_data_i[`CNR_RETRY_SHORT_LO +: 8];
          end
        end else begin
          accept_o <= want_acc;
          forward_o <= want_fwd && !do_rej;
          fwd_link_o <= out_link;
          reject_o <= do_rej;
          // Only nonposted non-broadcast requests get an abort reply.
          abort_reply_o <= do_rej && pkt_nonposted_i &&
                           (pkt_kind_i == `CNR_KIND_DOWN ||
                            pkt_kind_i == `CNR_KIND_UP);
        end
      end
    end
  end
endmodule

// ===== verification/cnr_link_src.sv
// Link-side packet source that presents headers to the router.
`timescale 1ns/1ps
module cnr_link_src (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Send request from the bench and consume pulse from the router.
  input wire go_i,
  input wire ready_i,
  // Packet presented.
  output reg valid_o
);
  // Valid is held until the consume pulse so no header is ever lost.
  always @(posedge clk_i) begin
    if (rst_i || ready_i) begin
      valid_o <= 1'b0;
    end else if (go_i) begin
      valid_o <= 1'b1;
    end
  end
endmodule

// ===== verification/cnr_router_monitor.sv
// Checker of routing outcomes and bus timing for the chain node router.
`timescale 1ns/1ps
`include "cnr_defines.vh"
module cnr_router_monitor (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Packet side.
  input wire pkt_valid_i,
  input wire pkt_link_i,
  input wire [2:0] pkt_kind_i,
  input wire pkt_nonposted_i,
  input wire pkt_ready_o,
  input wire accept_o,
  input wire forward_o,
  input wire fwd_link_o,
  input wire reject_o,
  input wire abort_reply_o,
  input wire pend_o,
  input wire fc_valid_o,
  input wire fc_error_o,
  // Bus side.
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Flow-control packets end here and never take a routing outcome.
  a_fc_consumed: assert property (
    (fc_valid_o || fc_error_o) |-> pkt_ready_o && !accept_o && !forward_o)
    else $error("flow-control packet was routed");
  a_bcast_both: assert property (
    pkt_ready_o && pkt_kind_i == `CNR_KIND_BCAST && !reject_o
    |-> accept_o && forward_o) else $error("broadcast not taken and sent");
  a_fwd_opposite: assert property (
    pkt_ready_o && forward_o |-> fwd_link_o != pkt_link_i)
    else $error("forward went back on arrival link");
  a_abort_np: assert property (
    abort_reply_o |-> reject_o && pkt_nonposted_i)
    else $error("abort reply without nonposted reject");
  a_fwd_or_reject: assert property (
    pkt_ready_o |-> !(forward_o && reject_o))
    else $error("packet both forwarded and rejected");
  a_pend_held: assert property (
    pend_o |-> pkt_valid_i && !accept_o && !forward_o)
    else $error("pend without a held packet");
  a_out_w_ready: assert property (
    (accept_o || forward_o || reject_o) |-> pkt_ready_o)
    else $error("outcome pulse without consume pulse");
  // The consume pulse lasts one cycle, so a packet is never taken twice.
  a_ready_pulse: assert property (pkt_ready_o |=> !pkt_ready_o)
    else $error("consume pulse longer than one cycle");
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus ack late");
endmodule
bind cnr_router cnr_router_monitor mon (.*);

// ===== verification/test_cnr_router.sv
// Bench for the chain node router: setup, routing and flow control.
`timescale 1ns/1ps
`include "cnr_defines.vh"
module test_cnr_router;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg go = 1'b0;
  reg lk = 1'b0;
  reg np = 1'b0, cp = 1'b0, br = 1'b0, own = 1'b0;
  reg [63:0] dat = 64'h0;
  reg [2:0] knd = 3'h0;
  reg [4:0] tag = 5'h0;
  reg [39:0] adr = 40'h0;
  reg [1:0] term = 2'h0;
  reg [1:0] idn = 2'h3;
  reg [3:0] wa = 4'h0;
  reg [31:0] wd = 32'h0;
  reg we = 1'b0, cyc = 1'b0;
  reg [31:0] rd;
  integer error_cnt = 0;
  integer checks = 0;
  integer n;
  wire vld, rdy, acc, fwd, fl, rej, ab, pnd, fcv, fce, ack;
  wire [2:0] fset;
  wire [3:0] fpr;
  wire [7:0] frp;
  wire [31:0] dq;
  // Free-running core clock.
  always #5 clk_i = ~clk_i;
  cnr_link_src src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
    .ready_i(rdy), .valid_o(vld));
  cnr_router uut (.clk_i(clk_i), .rst_i(rst_i), .pkt_valid_i(vld),
    .pkt_link_i(lk), .pkt_data_i(dat), .pkt_kind_i(knd),
    .pkt_nonposted_i(np), .pkt_compat_i(cp), .pkt_bridge_i(br),
    .pkt_tag_i(tag), .pkt_addr_i(adr), .addr_owned_i(own),
    .pkt_ready_o(rdy), .terminus_i(term), .init_done_i(idn),
    .accept_o(acc), .forward_o(fwd), .fwd_link_o(fl), .reject_o(rej),
    .abort_reply_o(ab), .pend_o(pnd), .fc_valid_o(fcv), .fc_set_o(fset),
    .fc_private_o(fpr), .fc_retry_ptr_o(frp), .fc_error_o(fce),
    .adr_i(wa), .dat_i(wd), .sel_i(4'hF), .we_i(we), .cyc_i(cyc),
    .stb_i(cyc), .dat_o(dq), .ack_o(ack));
  // Verdict; the only place the run ends.
  task end_sim;
    begin
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
    begin
      checks = checks + 1;
      if (e !== s) begin
        error_cnt = error_cnt + 1;
        $display("wrong value %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  // One classic bus cycle; the answer is taken at the edge that sees ack.
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      wa <= a;
      wd <= d;
      for (n = 0; n < 20 && ack !== 1'b1; n = n + 1)
        @(posedge clk_i);
      rd = dq;
      cyc <= 1'b0;
      if (n == 20) begin
        chk("timeout", 1, 0);
        end_sim;
      end
    end
  endtask
  // Present one header; outcome is read in the consume cycle.
  task pkt(input [2:0] k, input l, input [3:0] f, input [4:0] t,
    input [39:0] a, input [63:0] d, input [4:0] e);
    begin
      @(posedge clk_i);
      knd <= k;
      lk <= l;
      {np, cp, br, own} <= f;
      tag <= t;
      adr <= a;
      dat <= d;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      for (n = 0; n < 20 && rdy !== 1'b1; n = n + 1)
        @(posedge clk_i);
      if (n == 20) begin
        chk("timeout", 1, 0);
        end_sim;
      end else begin
        chk("outcome", {27'h0, e}, {27'h0, acc, fwd, rej, ab, fce});
        if (e[3])
          chk("fwd_link", {31'h0, ~l}, {31'h0, fl});
      end
    end
  endtask
  // Main sequence: setup, routing table, flow control, link states.
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, `CNR_BUS_CTRL, 0);
    chk("ctrl", 32'h00010000, rd);
    bus(0, `CNR_BUS_CREDIT, 0);
    chk("credit", 32'h0, rd);
    bus(1, `CNR_BUS_CTRL, 32'h02010205);
    bus(1, `CNR_BUS_PEER, 32'h00000008);
    bus(0, `CNR_BUS_CTRL, 0);
    chk("ctrl", 32'h02010205, rd);
    bus(0, `CNR_BUS_PEER, 0);
    chk("peer", 32'h00000008, rd);
    pkt(`CNR_KIND_BCAST, 0, 4'h0, 0, 40'h10, 0, 5'h18);
    pkt(`CNR_KIND_DOWN, 0, 4'h1, 2, 40'h10, 0, 5'h10);
    pkt(`CNR_KIND_DOWN, 1, 4'h0, 0, 40'h10, 0, 5'h08);
    pkt(`CNR_KIND_DOWN, 0, 4'h5, 0, 40'h10, 0, 5'h08);
    pkt(`CNR_KIND_UP, 0, 4'h1, 3, 40'h10, 0, 5'h10);
    pkt(`CNR_KIND_UP, 0, 4'h1, 3, 40'hFD00000000, 0, 5'h08);
    pkt(`CNR_KIND_UP, 1, 4'h1, 4, 40'h10, 0, 5'h08);
    pkt(`CNR_KIND_RESP, 0, 4'h2, 1, 40'h10, 0, 5'h10);
    pkt(`CNR_KIND_RESP, 0, 4'h2, 4, 40'h10, 0, 5'h08);
    pkt(`CNR_KIND_RESP, 1, 4'h0, 1, 40'h10, 0, 5'h08);
    // Two alternate-set releases accumulate in the credit counters.
    repeat (2)
      pkt(`CNR_KIND_FC, 0, 0, 0, 0, 64'h5AE40037, 5'h0);
    chk("fc", 32'h805A, {16'h0, fcv, fset, fpr, frp});
    bus(0, `CNR_BUS_CREDIT, 0);
    chk("credit", 32'h00006420, rd);
    pkt(`CNR_KIND_FC, 0, 0, 0, 0, 64'hA500443322119277, 5'h0);
    chk("fc", 32'hA9A5, {16'h0, fcv, fset, fpr, frp});
    pkt(`CNR_KIND_FC, 0, 0, 0, 0, 64'h00000237, 5'h1);
    pkt(`CNR_KIND_FC, 0, 0, 0, 0, 64'h00000337, 5'h1);
    term <= 2'h2;
    repeat (3) @(posedge clk_i);
    bus(0, `CNR_BUS_STAT, 0);
    chk("stat", 32'h0000020E, rd);
    pkt(`CNR_KIND_DOWN, 0, 4'h8, 0, 40'h10, 0, 5'h06);
    pkt(`CNR_KIND_DOWN, 0, 4'h0, 0, 40'h10, 0, 5'h04);
    term <= 2'h0;
    idn <= 2'h0;
    repeat (3) @(posedge clk_i);
    // The packet must wait until the link finishes its start-up.
    fork
      pkt(`CNR_KIND_DOWN, 0, 4'h0, 0, 40'h10, 0, 5'h08);
      begin
        repeat (8) @(posedge clk_i);
        chk("pend", 1, {31'h0, pnd});
        idn <= 2'h3;
      end
    join
    bus(1, `CNR_BUS_CTRL, 32'h02010705);
    idn <= 2'h0;
    repeat (3) @(posedge clk_i);
    pkt(`CNR_KIND_DOWN, 0, 4'h8, 0, 40'h10, 0, 5'h06);
    pkt(`CNR_KIND_DOWN, 0, 4'h4, 0, 40'h10, 0, 5'h10);
    end_sim;
  end
endmodule
